/* File: include/ee_consts.svh */
`ifndef EE_CONSTS_SVH
`define EE_CONSTS_SVH

// Fixed device-type pattern in the top nibble of the slave address byte.
`define EE_DEV_TYPE       4'ha
// Slave address byte field positions.
`define EE_STRAP_BIT      3
`define EE_BLK_HI_BIT     2
`define EE_BLK_LO_BIT     1
`define EE_RW_BIT         0
// Array organisation: 1024 bytes in 16-byte pages.
`define EE_ADDR_W         10
`define EE_PAGE_BYTES     16
// Bit counter values: last data bit done, acknowledge clock done.
`define EE_CNT_BYTE       4'h7
`define EE_CNT_ACK        4'h8
// Self-timed write cycle, longest time, and the system clock period.
`define EE_WR_TIME_NS     5000000
`define EE_CLK_PERIOD_NS  100
`define EE_WR_CYCLES      (`EE_WR_TIME_NS / `EE_CLK_PERIOD_NS)

`endif

/* File: include/ee_pkg.sv */
`default_nettype none

// Types shared by the serial memory slave.
package ee_pkg;

   // Protocol states of the link-side byte engine.
   typedef enum logic [2:0] {
      ee_idle,
      ee_dev,
      ee_waddr,
      ee_wdata,
      ee_rdata
   } ee_state_e;

endpackage

`default_nettype wire

/* File: rtl/ee_slave.sv */
`include "ee_consts.svh"
`default_nettype none

module ee_slave #(
   parameter int unsigned WR_CYCLES  = `EE_WR_CYCLES,
   parameter int unsigned ADDR_W     = `EE_ADDR_W,
   parameter int unsigned PAGE_BYTES = `EE_PAGE_BYTES
) (
   input  wire logic clock,
   input  wire logic srst,
   input  wire logic scl,
   input  wire logic sda_in,
   output var  logic sda_out,
   output var  logic sda_oe,
   input  wire logic chip_select_strap,
   input  wire logic write_protect,
   output var  logic busy,
   output var  logic standby
);
   import ee_pkg::*;

   // Width of the in-page byte index and of the write timer.
   localparam int unsigned PW = $clog2(PAGE_BYTES);
   localparam int unsigned TW = $clog2(WR_CYCLES + 1);

   // array organisation
   // Nonvolatile array, written only by the system side in the clock that starts busy.
   // It holds one byte per location across all four blocks.
   // The link side only reads it, and only outside a write cycle,
   // so the bytes it sees never change while they are being read.
   logic [7:0]        mem_q [0:(1 << ADDR_W) - 1];

   // Link side state, clocked by the bus clock.
   logic              sda_hi_q;        // Data level sampled at the clock rise.
   ee_state_e         st_q;            // Protocol state.
   logic [3:0]        cnt_q;           // Clocks completed in the current byte.
   logic [6:0]        shift_q;         // Received bits so far.
   logic              rd_q;            // Direction bit of the last address byte.
   logic [ADDR_W-1:0] addr_q;          // Internal address counter.
   logic [7:0]        tx_q;            // Byte being sent to the master.
   logic              oe_q;            // Pulls the data line low when set.
   logic              armed_q;         // Page buffer holds data to program.
   logic [7:0]        pg_q [0:PAGE_BYTES-1];
   logic [PAGE_BYTES-1:0] pg_vld_q;    // Which page buffer bytes were loaded.
   logic [ADDR_W-PW-1:0]  pg_base_q;   // Page number of the buffered bytes.
   logic              strap_s1_q;      // Strap pin synchroniser.
   logic              strap_s2_q;
   logic              busy_s1_q;       // Busy level brought into the link side.
   logic              busy_s2_q;

   // Stop detector, clocked by the data line itself.
   logic              stp_q;

   // System side state.
   logic              stp_s1_q;        // Stop level synchroniser and edge stage.
   logic              stp_s2_q;
   logic              stp_s3_q;
   logic              arm_s1_q;        // Armed level synchroniser.
   logic              arm_s2_q;
   logic              wp_s1_q;         // Write-protect pin synchroniser.
   logic              wp_s2_q;
   logic              busy_q;          // Internal write cycle running.
   logic [TW-1:0]     tmr_q;           // Write cycle timer.
   logic              standby_q;       // Low-power standby indication.
   logic              sda_out_q;       // Open-drain output level, always low.

   // Link side decode.
   logic              start_w;
   logic [7:0]        byte_w;
   logic              byte_end_w;
   logic              ack_end_w;
   logic              match_w;
   logic              load_w;
   logic [7:0]        rd_byte_w;
   logic [ADDR_W-1:0] addr_inc_w;
   logic [ADDR_W-1:0] page_inc_w;
   logic [PW-1:0]     pg_idx_w;
   ee_state_e         ack_next_w;

   // System side decode.
   logic              stop_rise_w;
   logic              prog_w;
   logic              tmr_end_w;

   // start detect: the data line was last seen high and is low at the fall
   // so it fell while the clock was high; data bits never change there.
   // The last-seen level also follows a stop, which raises the line with the
   // clock high, so the start that follows a stop is not missed.
   assign start_w    = sda_hi_q & ~sda_in;
   assign byte_w     = {shift_q, sda_hi_q};
   assign byte_end_w = (cnt_q == `EE_CNT_BYTE);
   assign ack_end_w  = (cnt_q == `EE_CNT_ACK);

   // device type, strap match, busy gate: the address byte is taken only
   // when the type nibble and the strap bit agree and no write cycle runs.
   assign match_w = (byte_w[7:4] == `EE_DEV_TYPE)
                  & (byte_w[`EE_STRAP_BIT] == strap_s2_q)
                  & ~busy_s2_q;

   // read continue: a byte is loaded after a read address or a master acknowledge.
   assign load_w = ack_end_w & (((st_q == ee_dev) & rd_q)
                              | ((st_q == ee_rdata) & ~sda_hi_q));

   // current byte: the counter already points at the last access plus one.
   assign rd_byte_w  = mem_q[addr_q];
   // array rollover: the counter wraps from the top location to zero.
   assign addr_inc_w = addr_q + ADDR_W'(1);
   // page wrap: only the low bits count, the page number stays.
   assign page_inc_w = {addr_q[ADDR_W-1:PW], PW'(addr_q[PW-1:0] + PW'(1))};
   assign pg_idx_w   = addr_q[PW-1:0];

   // State after the acknowledge clock when no read byte is loaded.
   assign ack_next_w = (st_q == ee_dev)   ? ee_waddr :
                       (st_q == ee_waddr) ? ee_wdata :
                       (st_q == ee_wdata) ? ee_wdata : ee_idle;

   // Samples the data line on each clock rise, as the master holds it stable there.
   // Any rise of the data line sets the flop at once; a rise with the clock high
   // is a stop, after which a falling line must read as a start.
   // A rise with the clock low is harmless: the next clock rise samples again
   // before any clock fall reads the flop.
   always_ff @(posedge scl or posedge sda_in) begin
      if (sda_in) begin
         sda_hi_q <= 1'b1;
      end else begin
         sda_hi_q <= 1'b0;
      end
   end

   // Brings the strap pin and the busy level into the link clock.
   always_ff @(negedge scl) begin
      strap_s1_q <= chip_select_strap;
      strap_s2_q <= strap_s1_q;
      busy_s1_q  <= busy_q;
      busy_s2_q  <= busy_s1_q;
   end

   // Byte engine, updated on the clock fall so the data line changes while low.
   always_ff @(negedge scl) begin
      if (start_w) begin
         // resync: a start returns every frame to the address phase.
         st_q    <= ee_dev;
         cnt_q   <= 4'h0;
         oe_q    <= 1'b0;
         armed_q <= 1'b0;
      end else if (st_q == ee_idle) begin
         // wait for start: all other activity is ignored.
         cnt_q <= 4'h0;
         oe_q  <= 1'b0;
      end else begin
         cnt_q   <= ack_end_w ? 4'h0 : cnt_q + 4'h1;
         shift_q <= byte_w[6:0];
         if (byte_end_w) begin
            unique case (st_q)
               ee_dev: begin
                  if (match_w) begin
                     // acknowledge the address byte; block bits, direction.
                     oe_q                      <= 1'b1;
                     addr_q[ADDR_W-1:ADDR_W-2] <= byte_w[`EE_BLK_HI_BIT:`EE_BLK_LO_BIT];
                     rd_q                      <= byte_w[`EE_RW_BIT];
                  end else begin
                     // withhold acknowledge: polling sees no answer while busy.
                     st_q <= ee_idle;
                  end
               end
               ee_waddr: begin
                  // full address: block bits over the received byte address.
                  oe_q     <= 1'b1;
                  addr_q   <= {addr_q[ADDR_W-1:ADDR_W-2], byte_w};
                  pg_vld_q <= '0;
               end
               ee_wdata: begin
                  // page byte: acknowledge at once and buffer it.
                  oe_q               <= 1'b1;
                  pg_q[pg_idx_w]     <= byte_w;
                  pg_vld_q[pg_idx_w] <= 1'b1;
                  pg_base_q          <= addr_q[ADDR_W-1:PW];
                  addr_q             <= page_inc_w;
                  armed_q            <= 1'b1;
               end
               ee_rdata: begin
                  // Release the line so the master can answer.
                  oe_q <= 1'b0;
               end
               default: begin
                  st_q <= ee_idle;
               end
            endcase
         end else if (ack_end_w) begin
            if (load_w) begin
               // read at the counter, which a dummy write may have set.
               st_q   <= ee_rdata;
               tx_q   <= rd_byte_w;
               oe_q   <= ~rd_byte_w[7];
               addr_q <= addr_inc_w;
            end else begin
               // no master acknowledge ends the read and frees the line.
               st_q <= ack_next_w;
               oe_q <= 1'b0;
            end
         end else if (st_q == ee_rdata) begin
            // Shifts out the next bit, most significant first.
            tx_q <= {tx_q[6:0], 1'b0};
            oe_q <= ~tx_q[6];
         end
      end
   end

   // stop detect: the last data rise with the clock high marks a stopped bus
   // every frame raises the line with the clock low in its address byte.
   always_ff @(posedge sda_in) begin
      stp_q <= scl;
   end

   // Synchronisers into the system clock for pins and link levels.
   always_ff @(posedge clock) begin
      if (srst) begin
         stp_s1_q <= 1'b0;
         stp_s2_q <= 1'b0;
         stp_s3_q <= 1'b0;
         arm_s1_q <= 1'b0;
         arm_s2_q <= 1'b0;
         wp_s1_q  <= 1'b0;
         wp_s2_q  <= 1'b0;
      end else begin
         stp_s1_q <= stp_q;
         stp_s2_q <= stp_s1_q;
         stp_s3_q <= stp_s2_q;
         arm_s1_q <= armed_q;
         arm_s2_q <= arm_s1_q;
         wp_s1_q  <= write_protect;
         wp_s2_q  <= wp_s1_q;
      end
   end

   assign stop_rise_w = stp_s2_q & ~stp_s3_q;
   // program at stop; write protect blocks it.
   assign prog_w      = stop_rise_w & arm_s2_q & ~wp_s2_q & ~busy_q;
   assign tmr_end_w   = (tmr_q == TW'(WR_CYCLES - 1));

   // single cycle: all buffered bytes of the page go into the array together.
   always_ff @(posedge clock) begin
      if (prog_w) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            if (pg_vld_q[i]) begin
               mem_q[{pg_base_q, PW'(i)}] <= pg_q[i];
            end
         end
      end
   end

   // write timer: busy holds for the full write time, then drops.
   always_ff @(posedge clock) begin
      if (srst) begin
         busy_q <= 1'b0;
         tmr_q  <= '0;
      end else if (prog_w) begin
         busy_q <= 1'b1;
         tmr_q  <= '0;
      end else if (busy_q) begin
         busy_q <= ~tmr_end_w;
         tmr_q  <= tmr_q + TW'(1);
      end
   end

   // standby: bus stopped and no write cycle running, also out of reset.
   always_ff @(posedge clock) begin
      if (srst) begin
         standby_q <= 1'b1;
         sda_out_q <= 1'b0;
      end else begin
         standby_q <= stp_s2_q & ~busy_q & ~prog_w;
         sda_out_q <= 1'b0;
      end
   end

   // strap: the pad pulls a floating pin low, so the logic sees zero.
   assign sda_oe  = oe_q;
   assign sda_out = sda_out_q;
   assign busy    = busy_q;
   assign standby = standby_q;

   // Checks on the link side.
   nomatch_nack_a: assert property (@(negedge scl) disable iff (srst)
      (!start_w && st_q == ee_dev && byte_end_w && byte_w[7:4] != `EE_DEV_TYPE) |=> !oe_q)
      else $error("Acknowledged a foreign device type.");
   strap_nack_a: assert property (@(negedge scl) disable iff (srst)
      (!start_w && st_q == ee_dev && byte_end_w && byte_w[`EE_STRAP_BIT] != strap_s2_q)
      |=> !oe_q ##1 !oe_q)
      else $error("Acknowledged a strap mismatch.");
   busy_nack_a: assert property (@(negedge scl) disable iff (srst)
      (!start_w && st_q == ee_dev && byte_end_w && busy_s2_q) |=> (st_q == ee_idle && !oe_q))
      else $error("Answered while a write cycle runs.");
   addr_ack_a: assert property (@(negedge scl) disable iff (srst)
      (!start_w && st_q == ee_dev && byte_end_w && match_w) |=> oe_q ##1 (rd_q || !oe_q))
      else $error("Missing acknowledge on the ninth clock.");
   start_idle_a: assert property (@(negedge scl) disable iff (srst)
      start_w |=> (st_q == ee_dev && cnt_q == 4'h0 && !oe_q && !armed_q))
      else $error("Start did not resync the engine.");
   page_wrap_a: assert property (@(negedge scl) disable iff (srst)
      (!start_w && st_q == ee_wdata && byte_end_w)
      |=> (addr_q[ADDR_W-1:PW] == $past(addr_q[ADDR_W-1:PW])
           && addr_q[PW-1:0] == PW'($past(addr_q[PW-1:0]) + PW'(1))))
      else $error("Page write address left its page.");
   read_inc_a: assert property (@(negedge scl) disable iff (srst)
      (!start_w && load_w) |=> (addr_q == ADDR_W'($past(addr_q) + ADDR_W'(1))
                                && tx_q == $past(rd_byte_w)))
      else $error("Read counter did not advance.");
   blk_addr_a: assert property (@(negedge scl) disable iff (srst)
      (!start_w && st_q == ee_waddr && byte_end_w)
      |=> addr_q == {$past(addr_q[ADDR_W-1:ADDR_W-2]), $past(byte_w)})
      else $error("Word address not formed from block bits.");

   // Checks on the system side.
   prog_go_a: assert property (@(posedge clock) disable iff (srst)
      (stop_rise_w && arm_s2_q && !wp_s2_q && !busy_q) |=> busy_q [*8])
      else $error("Stop after a write did not start programming.");
   wp_block_a: assert property (@(posedge clock) disable iff (srst)
      (!busy_q && wp_s2_q) |=> !busy_q)
      else $error("Programming started while write protected.");
   wr_time_a: assert property (@(posedge clock) disable iff (srst)
      (busy_q && tmr_end_w) |=> !busy_q ##1 (standby_q == $past(stp_s2_q && !prog_w)))
      else $error("Write cycle overran its time.");
   standby_a: assert property (@(posedge clock) disable iff (srst)
      (busy_q || !stp_s2_q) |=> !standby_q)
      else $error("Standby shown while active.");

   // Main scenarios.
   page_full_c: cover property (@(negedge scl) disable iff (srst)
      st_q == ee_wdata && byte_end_w && addr_q[PW-1:0] == PW'(PAGE_BYTES - 1));
   seq_read_c: cover property (@(negedge scl) disable iff (srst)
      load_w && st_q == ee_rdata);
   poll_nack_c: cover property (@(negedge scl) disable iff (srst)
      st_q == ee_dev && byte_end_w && busy_s2_q);
   prog_done_c: cover property (@(posedge clock) disable iff (srst)
      busy_q && tmr_end_w);

endmodule

`default_nettype wire

/* File: dv/ee_master.sv */
`default_nettype none

// Two-wire bus master model: it makes the bus clock and pulls the data line.
module ee_master (
   output var  logic scl,
   output var  logic sda_m,
   input  wire logic sda
);
   timeunit 1ns;
   timeprecision 1ns;

   localparam int Q = 12;  // Quarter of the 48 ns bit period.

   // The bus idles with clock and data high; the clock stands still between frames.
   // The power-up data rise with the clock high reads as a stop, so the slave
   // starts out idle with a known line level.
   initial begin
      scl   = 1'b1;
      sda_m = 1'b0;
      #Q sda_m = 1'b1;
   end

   // one clock per bit
   // Data changes only while the clock is low and is sampled in the high phase.
   task automatic bit_io(input logic b, output logic r);
      scl = 1'b0;
      #Q sda_m = b;
      #Q scl = 1'b1;
      #Q r = sda;
      #Q;
   endtask

   // first or repeated start
   // The line is freed under a low clock first if anybody holds it low.
   task automatic start();
      if (sda !== 1'b1) begin
         scl = 1'b0;
         #Q sda_m = 1'b1;
         #Q scl = 1'b1;
      end
      #(2*Q) sda_m = 1'b0;
      #(2*Q);
   endtask

   // One byte MSB first, then the acknowledge clock.
   task automatic xfer(input logic [7:0] tx, input logic ak, output logic [7:0] rx,
                       output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
      bit_io(ak, ack);
   endtask

   // closing stop
   // The gap after the stop lets the system clock catch it before the next start.
   task automatic stop();
      scl = 1'b0;
      #Q sda_m = 1'b0;
      #Q scl = 1'b1;
      #(2*Q) sda_m = 1'b1;
      #500;
   endtask

   // bus recovery
   // Up to nine clocks until the line reads high, then a start.
   task automatic recover();
      logic r;
      for (int i = 0; i < 9; i++) begin
         bit_io(1'b1, r);
         if (r === 1'b1) break;
      end
      start();
   endtask
endmodule

`default_nettype wire

/* File: dv/serial_eeprom_two_wire_slave_tb.sv */
`default_nettype none

// Self-checking bench for the serial memory slave.
module serial_eeprom_two_wire_slave_tb;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int unsigned WR = 20;  // Shortened write cycle in clocks.

   logic       clock             = 1'b0;
   logic       srst              = 1'b1;
   logic       chip_select_strap = 1'b0;  // Zero stands for a floating strap.
   logic       write_protect     = 1'b0;
   wire logic  scl;
   wire logic  sda_m;
   wire logic  sda;
   wire logic  sda_out;
   wire logic  sda_oe;
   wire logic  busy;
   wire logic  standby;
   int         miscompares       = 0;
   int         checked           = 0;
   logic [7:0] mem [1024];             // Expected array contents.
   logic [7:0] rx;
   logic       ak;

   // Wired-AND data line with a pull-up.
   assign sda = sda_m & ~(sda_oe === 1'b1 && sda_out === 1'b0);

   // The system clock runs at 10 MHz.
   always #50 clock = ~clock;

   ee_master m (.scl(scl), .sda_m(sda_m), .sda(sda));

   ee_slave #(.WR_CYCLES(WR)) dut (
      .clock(clock), .srst(srst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .chip_select_strap(chip_select_strap),
      .write_protect(write_protect), .busy(busy), .standby(standby));

   // Prints the verdict and ends the run.
   task automatic end_of_test();
      if (miscompares == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Compares and counts.
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Slave address byte from strap and block bits and direction.
   function automatic logic [7:0] dev(input logic [2:0] sb, input logic rw);
      return {4'ha, sb, rw};
   endfunction

   // Sends a byte and judges whether the slave acknowledged.
   task automatic put(input logic [7:0] b, input logic exp_ack);
      m.xfer(b, 1'b1, rx, ak);
      check({7'h0, ak}, {7'h0, ~exp_ack});
   endtask

   // Write frame with n data bytes; the model wraps within the page.
   task automatic write(input logic [9:0] a, input int n, input logic [7:0] v,
                        input logic exp);
      m.start();
      put(dev({1'b0, a[9:8]}, 1'b0), 1'b1);
      put(a[7:0], 1'b1);
      for (int i = 0; i < n; i++) begin
         put(v + 8'(i), 1'b1);
         if (exp) mem[{a[9:4], a[3:0] + 4'(i)}] = v + 8'(i);
      end
      m.stop();
      @(posedge clock);
      #1;
      check({7'h0, busy}, {7'h0, exp});
   endtask

   // Waits for the write cycle to end and checks standby.
   task automatic done();
      for (int n = 0; n < WR + 10 && busy !== 1'b0; n++) @(posedge clock);
      repeat (2) @(posedge clock);
      #1;
      check({7'h0, standby}, 8'h01);
   endtask

   // Random or current-address read of n bytes, last one unacknowledged.
   task automatic read(input logic [9:0] a, input int n, input logic rnd);
      m.start();
      if (rnd) begin
         put(dev({1'b0, a[9:8]}, 1'b0), 1'b1);
         put(a[7:0], 1'b1);
         m.start();
      end
      put(dev({1'b0, a[9:8]}, 1'b1), 1'b1);
      for (int i = 0; i < n; i++) begin
         m.xfer(8'hff, (i == n - 1), rx, ak);
         check(rx, mem[a + 10'(i)]);
      end
      m.stop();
   endtask

   // Byte write, polling while busy, then read back.
   task automatic s_byte();
      write(10'h123, 1, 8'h3c, 1'b1);
      m.start();
      put(dev(3'h0, 1'b0), 1'b0);
      m.stop();
      done();
      m.start();
      put(dev(3'h0, 1'b0), 1'b1);
      m.stop();
      read(10'h123, 1, 1'b1);
   endtask

   // Eighteen bytes from near the page end wrap and overwrite.
   task automatic s_page();
      write(10'h2fe, 18, 8'h40, 1'b1);
      done();
      read(10'h2f0, 16, 1'b1);
   endtask

   // Roll-over from the top of the array, then a current-address read.
   task automatic s_roll();
      write(10'h3ff, 1, 8'h77, 1'b1);
      done();
      write(10'h000, 1, 8'h88, 1'b1);
      done();
      read(10'h3ff, 2, 1'b1);
      read(10'h3ff, 1, 1'b1);
      read(10'h000, 1, 1'b0);
   endtask

   // Wrong type nibble, strap mismatch, no start, abort and recovery.
   task automatic s_refuse();
      m.start();
      put(8'hb0, 1'b0);
      m.stop();
      m.xfer(dev(3'h0, 1'b0), 1'b1, rx, ak);
      check({7'h0, ak}, 8'h01);
      m.start();
      put(dev(3'h4, 1'b0), 1'b0);
      m.stop();
      @(posedge clock);
      #1 chip_select_strap = 1'b1;
      m.start();
      put(dev(3'h4, 1'b0), 1'b1);
      repeat (3) m.bit_io(1'b0, ak);
      m.recover();
      put(dev(3'h4, 1'b1), 1'b1);
      m.xfer(8'hff, 1'b1, rx, ak);
      m.stop();
      @(posedge clock);
      #1 chip_select_strap = 1'b0;
   endtask

   // Protected writes are acknowledged but program nothing.
   task automatic s_wp();
      @(posedge clock);
      #1 write_protect = 1'b1;
      repeat (3) @(posedge clock);
      write(10'h123, 1, 8'h5a, 1'b0);
      read(10'h123, 1, 1'b1);
      @(posedge clock);
      #1 write_protect = 1'b0;
   endtask

   // Reset for 16 clocks, then the scenarios in turn.
   initial begin
      repeat (16) @(posedge clock);
      #1 srst = 1'b0;
      repeat (4) @(posedge clock);
      #1;
      check({7'h0, standby}, 8'h01);
      s_byte();
      s_page();
      s_roll();
      s_refuse();
      s_wp();
      end_of_test();
   end

   // Watchdog well beyond the expected run of some tens of microseconds.
   initial begin
      #1000000;
      miscompares++;
      end_of_test();
   end
endmodule

`default_nettype wire
